/* File: sndgen_top.v */
/*
 * three channel programmable sound generator with apb register access.
 * assumes: one 20 MHz clock, apb master on the same clock, async active-low reset.
 */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "sndgen_defines.vh"

// What this block does
// R1 - sixteen byte registers control every sound function
// R2 - sound runs on its own once registers are loaded
// R3 - three independent channels a, b, c each with tone, mix, level
// R4 - tone is clock divided by 16 then by 12-bit tone period
// R5 - tone period takes coarse low nibble and whole fine byte
// R6 - fine/coarse pairs at registers 0-1, 2-3, 4-5
// R7 - noise clock divided by 16 then by 5-bit period in register 6
// R8 - pseudo-random noise output shared by all three mixers
// R9 - mixer enable bits are active low
// R10 - register 7 bits 2..0 gate tone, bits 5..3 gate noise
// R11 - registers 8-10 hold level, mode bit 4, upper bits unused
// R12 - fixed mode uses written level, else envelope value
// R13 - each converter outputs one of sixteen levels
// R14 - envelope rate is clock divided by 256 then by 16-bit period
// R15 - envelope period high byte register 12, low byte register 11
// R16 - envelope steps a 4-bit counter through sixteen states
// R17 - sixteen steps take exactly one envelope period; the code takes one envelope period for each step
// R18 - shape picks count direction and single or repeating run
// R19 - register 13 bits 3..0 are continue, attack, alternate, hold
// R20 - attack counts up; no continue rests at zero; alternate flips; hold freezes
// R21 - writing the shape register restarts the envelope
module sndgen_top
(
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output wire        pslverr_o,
  // channel levels to the converters
  output reg  [3:0]  level_a_o,
  output reg  [3:0]  level_b_o,
  output reg  [3:0]  level_c_o
);

////////////////////////////////////////////////////////////////////////////////
// reset synchroniser

reg        rst_meta_r;
reg        rst_sync_r;
wire       rst_n;

always @(posedge ref_clk_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    rst_meta_r <= 1'b0;
    rst_sync_r <= 1'b0;
  end
  else
  begin
    rst_meta_r <= 1'b1;
    rst_sync_r <= rst_meta_r;
  end
end

assign rst_n = rst_sync_r;

////////////////////////////////////////////////////////////////////////////////
// register file

reg  [7:0] regs_r [0:`SNDGEN_REG_COUNT-1];
reg  [3:0] env_step_r;
wire [3:0] reg_idx;
wire       wr_acc;
wire       shape_wr;

assign reg_idx   = paddr_i[`SNDGEN_ADDR_MSB:`SNDGEN_ADDR_LSB];
assign wr_acc    = psel_i & penable_i & pwrite_i & pstrb_i[0];
assign pready_o  = 1'b1;
assign pslverr_o = 1'b0;
assign shape_wr  = wr_acc & (reg_idx == `SNDGEN_IDX_ENVELOPE_SHAPE);

genvar gi;
generate
  for (gi = 0; gi < `SNDGEN_REG_COUNT; gi = gi + 1)
  begin : g_reg
    always @(posedge ref_clk_i or negedge rst_n)
    begin
      if (!rst_n)
        regs_r[gi] <= (gi == `SNDGEN_IDX_MIXER_ENABLE_N) ? `SNDGEN_MIX_RESET : `SNDGEN_REG_RESET;
      else if (wr_acc && (reg_idx == gi))
        regs_r[gi] <= pwdata_i[7:0]; // R1
    end
  end
endgenerate

// read data: byte in low lane, upper bits zero; reads with any of address bits 31..6 set return zero
always @(posedge ref_clk_i or negedge rst_n)
begin
  if (!rst_n)
    prdata_o <= 32'h0000_0000;
  else if (psel_i && !penable_i && !pwrite_i)
  begin
    if (paddr_i[31:6] != 26'h0)
      prdata_o <= 32'h0000_0000;
    else if (reg_idx == `SNDGEN_IDX_SPARE_E)
      prdata_o <= {24'h000000, 4'h0, env_step_r};
    else
      prdata_o <= {24'h000000, regs_r[reg_idx]};
  end
end

////////////////////////////////////////////////////////////////////////////////
// prescaler: the tone takes a tick every 8 clocks, the noise every 16

reg  [3:0] pre_cnt_r;
wire       tick8;
wire       tick16;

always @(posedge ref_clk_i or negedge rst_n)
begin
  if (!rst_n)
    pre_cnt_r <= 4'h0;
  else
    pre_cnt_r <= pre_cnt_r + 4'h1;
end

// a tone toggle per 8 x period clocks gives a full wave of 16 x period clocks
assign tick8  = (pre_cnt_r[2:0] == 3'h7); // R4
assign tick16 = (pre_cnt_r == 4'hf);      // R7

////////////////////////////////////////////////////////////////////////////////
// tone generators

function [11:0] tone_period;
  input [7:0] fine;
  input [7:0] coarse;
  begin
    tone_period = {coarse[3:0], fine}; // R5
  end
endfunction

reg  [11:0] tone_cnt_r [0:2];
reg  [2:0]  tone_out_r;
wire [11:0] tp [0:2];

assign tp[0] = tone_period(regs_r[`SNDGEN_IDX_TONE_FINE_A], regs_r[`SNDGEN_IDX_TONE_COARSE_A]); // R6
assign tp[1] = tone_period(regs_r[`SNDGEN_IDX_TONE_FINE_B], regs_r[`SNDGEN_IDX_TONE_COARSE_B]); // R6
assign tp[2] = tone_period(regs_r[`SNDGEN_IDX_TONE_FINE_C], regs_r[`SNDGEN_IDX_TONE_COARSE_C]); // R6

generate
  for (gi = 0; gi < 3; gi = gi + 1)
  begin : g_tone
    // toggles every period ticks of the divided clock; period 0 acts as 1
    always @(posedge ref_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        tone_cnt_r[gi] <= 12'h000;
        tone_out_r[gi] <= 1'b0;
      end
      else if (tick8)
      begin
        if (tone_cnt_r[gi] + 12'h001 >= tp[gi])
        begin
          tone_cnt_r[gi] <= 12'h000;
          tone_out_r[gi] <= ~tone_out_r[gi]; // R4 R3
        end
        else
          tone_cnt_r[gi] <= tone_cnt_r[gi] + 12'h001;
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// noise generator

reg  [4:0]  noise_cnt_r;
reg  [16:0] lfsr_r;
wire [4:0]  noise_period_value;

assign noise_period_value = regs_r[`SNDGEN_IDX_NOISE_PERIOD][4:0]; // R7

always @(posedge ref_clk_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    noise_cnt_r <= 5'h00;
    lfsr_r      <= `SNDGEN_LFSR_SEED;
  end
  else if (tick16)
  begin
    if (noise_cnt_r + 5'h01 >= noise_period_value)
    begin
      noise_cnt_r <= 5'h00;
      lfsr_r      <= {lfsr_r[0] ^ lfsr_r[3], lfsr_r[16:1]}; // R8
    end
    else
      noise_cnt_r <= noise_cnt_r + 5'h01; // R7
  end
end

////////////////////////////////////////////////////////////////////////////////
// envelope generator

localparam [2:0] ENV_RUN  = 3'b001;
localparam [2:0] ENV_HOLD = 3'b010;
localparam [2:0] ENV_IDLE = 3'b100;

reg  [2:0]  env_state_r;
reg  [15:0] env_cnt_r;
reg  [7:0]  env_pre_r;
reg         env_up_r;
wire [15:0] envelope_period_value;
wire [3:0]  shape;
wire        tick256;
wire        env_tick;

assign envelope_period_value = {regs_r[`SNDGEN_IDX_ENV_PERIOD_HIGH], regs_r[`SNDGEN_IDX_ENV_PERIOD_LOW]}; // R15
assign shape    = regs_r[`SNDGEN_IDX_ENVELOPE_SHAPE][3:0]; // R19
// one step per period ticks of clock/256: sixteen steps span sixteen envelope periods
assign env_tick = tick256 && (env_cnt_r + 16'h0001 >= envelope_period_value); // R14 R17

// own divide-by-256, restarted by a shape write so the first step has full length
always @(posedge ref_clk_i or negedge rst_n)
begin
  if (!rst_n)
    env_pre_r <= 8'h00;
  else if (shape_wr)
    env_pre_r <= 8'h00; // R21
  else
    env_pre_r <= env_pre_r + 8'h01;
end

assign tick256 = (env_pre_r == 8'hff); // R14

always @(posedge ref_clk_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    env_cnt_r   <= 16'h0000;
    env_step_r  <= 4'h0;
    env_up_r    <= 1'b0;
    env_state_r <= ENV_IDLE;
  end
  else if (shape_wr)
  begin
    env_cnt_r   <= 16'h0000;
    env_up_r    <= pwdata_i[`SNDGEN_SHAPE_ATTACK_BIT]; // R21 R20
    env_step_r  <= pwdata_i[`SNDGEN_SHAPE_ATTACK_BIT] ? 4'h0 : 4'hf; // R21
    env_state_r <= ENV_RUN;
  end
  else
  begin
    if (tick256)
      env_cnt_r <= env_tick ? 16'h0000 : env_cnt_r + 16'h0001;
    case (env_state_r)
      ENV_RUN:
      begin
        if (env_tick)
        begin
          if (env_step_r != (env_up_r ? 4'hf : 4'h0))
            env_step_r <= env_up_r ? env_step_r + 4'h1 : env_step_r - 4'h1; // R16 R18
          else if (!shape[`SNDGEN_SHAPE_CONT_BIT])
          begin
            env_step_r  <= 4'h0; // R20
            env_state_r <= ENV_HOLD;
          end
          else if (shape[`SNDGEN_SHAPE_HOLD_BIT])
          begin
            // hold freezes the end value, or the start value when alternating
            if (shape[`SNDGEN_SHAPE_ALT_BIT])
              env_step_r <= ~env_step_r; // R20
            env_state_r <= ENV_HOLD;
          end
          else if (shape[`SNDGEN_SHAPE_ALT_BIT])
          begin
            // the turning value stands again so every ramp keeps all sixteen states
            env_up_r <= ~env_up_r; // R20
          end
          else
            env_step_r <= env_up_r ? 4'h0 : 4'hf; // R18
        end
      end
      ENV_HOLD:
        env_state_r <= ENV_HOLD;
      ENV_IDLE:
        env_state_r <= ENV_IDLE;
      default:
        env_state_r <= ENV_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// mixers and amplitude control

function [3:0] chan_level;
  input       tone;
  input       noise;
  input [7:0] mix;
  input [1:0] ch;
  input [7:0] amp;
  input [3:0] envelope_step_value;
  reg         tone_on;
  reg         noise_on;
  reg   [3:0] fixed_level;
  begin
    // a disabled source reads as high, so a fully disabled channel holds its level
    tone_on     = tone | mix[ch]; // R9 R10
    noise_on    = noise | mix[`SNDGEN_MIX_NOISE_LSB + ch]; // R9 R10
    fixed_level = amp[3:0];
    if (tone_on & noise_on)
      chan_level = amp[`SNDGEN_AMP_MODE_BIT] ? envelope_step_value : fixed_level; // R11 R12
    else
      chan_level = 4'h0;
  end
endfunction

always @(posedge ref_clk_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    level_a_o <= 4'h0;
    level_b_o <= 4'h0;
    level_c_o <= 4'h0;
  end
  else
  begin
    level_a_o <= chan_level(tone_out_r[0], lfsr_r[0], regs_r[`SNDGEN_IDX_MIXER_ENABLE_N], 2'd0,
                            regs_r[`SNDGEN_IDX_AMPLITUDE_A], env_step_r); // R13 R2
    level_b_o <= chan_level(tone_out_r[1], lfsr_r[0], regs_r[`SNDGEN_IDX_MIXER_ENABLE_N], 2'd1,
                            regs_r[`SNDGEN_IDX_AMPLITUDE_B], env_step_r); // R13
    level_c_o <= chan_level(tone_out_r[2], lfsr_r[0], regs_r[`SNDGEN_IDX_MIXER_ENABLE_N], 2'd2,
                            regs_r[`SNDGEN_IDX_AMPLITUDE_C], env_step_r); // R13
  end
end

endmodule

/* File: sndgen_defines.vh */
/*
 * register offsets, field positions and divider constants of the sound generator.
 * assumes: included by the design file by bare name; byte registers sit one to an apb word.
 */
`ifndef SNDGEN_DEFINES_VH
`define SNDGEN_DEFINES_VH

// register indexes; byte address is four times the index
`define SNDGEN_IDX_TONE_FINE_A        4'h0
`define SNDGEN_IDX_TONE_COARSE_A      4'h1
`define SNDGEN_IDX_TONE_FINE_B        4'h2
`define SNDGEN_IDX_TONE_COARSE_B      4'h3
`define SNDGEN_IDX_TONE_FINE_C        4'h4
`define SNDGEN_IDX_TONE_COARSE_C      4'h5
`define SNDGEN_IDX_NOISE_PERIOD       4'h6
`define SNDGEN_IDX_MIXER_ENABLE_N     4'h7
`define SNDGEN_IDX_AMPLITUDE_A        4'h8
`define SNDGEN_IDX_AMPLITUDE_B        4'h9
`define SNDGEN_IDX_AMPLITUDE_C        4'ha
`define SNDGEN_IDX_ENV_PERIOD_LOW     4'hb
`define SNDGEN_IDX_ENV_PERIOD_HIGH    4'hc
`define SNDGEN_IDX_ENVELOPE_SHAPE     4'hd
`define SNDGEN_IDX_SPARE_E            4'he
`define SNDGEN_IDX_SPARE_F            4'hf
`define SNDGEN_REG_COUNT              16
`define SNDGEN_ADDR_MSB               5
`define SNDGEN_ADDR_LSB               2

// field positions
`define SNDGEN_AMP_MODE_BIT           4
`define SNDGEN_SHAPE_HOLD_BIT         0
`define SNDGEN_SHAPE_ALT_BIT          1
`define SNDGEN_SHAPE_ATTACK_BIT       2
`define SNDGEN_SHAPE_CONT_BIT         3
`define SNDGEN_MIX_NOISE_LSB          3

// reset value of every register except the mixer enable, then of the mixer enable
`define SNDGEN_REG_RESET              8'h00
`define SNDGEN_MIX_RESET              8'hff

// prescalers, envelope step count and noise seed
`define SNDGEN_TONE_PRESCALE          16
`define SNDGEN_ENV_PRESCALE           256
`define SNDGEN_ENV_STEPS              16
`define SNDGEN_LFSR_SEED              17'h00001

`endif

/* File: sndgen_chk_sva.sv */
/*
 * port checker for the sound generator.
 * assumes: bound to sndgen_top; registers are shadowed from apb writes.
 */
`timescale 1ns/1ps
`include "sndgen_defines.vh"
module sndgen_chk
(
  // clock and reset
  input wire        ref_clk_i,
  input wire        rst_n_i,
  // apb
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0]  pstrb_i,
  input wire        pready_o,
  input wire [31:0] prdata_o,
  input wire        pslverr_o,
  // levels
  input wire [3:0]  level_a_o,
  input wire [3:0]  level_b_o,
  input wire [3:0]  level_c_o
);
  logic [15:0][7:0] sh_r;
  wire              wr = psel_i & penable_i & pwrite_i & pstrb_i[0];
  wire [3:0]        ix = paddr_i[5:2];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      sh_r    <= '0;
      sh_r[7] <= `SNDGEN_MIX_RESET;
    end
    else if (wr)
      sh_r[ix] <= pwdata_i[7:0];
  ////////////////////////////////////////////////////////////////////////////////
  rdy_const_a:
    assert property (pready_o) else $error("pready low");
  err_low_a:
    assert property (!pslverr_o) else $error("pslverr high");
  rd_data_a:
    assert property (psel_i && !penable_i && !pwrite_i && paddr_i[31:6] == 26'h0 && ix != 4'he
      |=> prdata_o == {24'h0, $past(sh_r[ix])}) else $error("read data wrong");
  fix_a_a:
    assert property (!sh_r[8][4] && sh_r[7][0] && sh_r[7][3] && $stable(sh_r[8]) && $stable(sh_r[7])
      |-> level_a_o == sh_r[8][3:0]) else $error("level a not fixed");
  fix_c_a:
    assert property (!sh_r[10][4] && sh_r[7][2] && sh_r[7][5] && $stable(sh_r[10]) && $stable(sh_r[7])
      |-> level_c_o == sh_r[10][3:0]) else $error("level c not fixed");
  zero_b_a:
    assert property (!sh_r[9][4] && sh_r[9][3:0] == 4'h0 && $stable(sh_r[9])
      |-> level_b_o == 4'h0) else $error("level b not zero");
  env_up_a:
    assert property (wr && ix == 4'hd && pwdata_i[2] && sh_r[8][4] && sh_r[7][0] && sh_r[7][3]
      |-> ##[2:3] level_a_o == 4'h0) else $error("rising envelope not at zero");
  env_down_a:
    assert property (wr && ix == 4'hd && !pwdata_i[2] && sh_r[8][4] && sh_r[7][0] && sh_r[7][3]
      |-> ##[2:3] level_a_o == 4'hf) else $error("falling envelope not at top");
endmodule
bind sndgen_top sndgen_chk sndgen_chk_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .level_a_o(level_a_o),
  .level_b_o(level_b_o), .level_c_o(level_c_o));

/* File: sndgen_host.sv */
/*
 * apb host model that loads the sound registers.
 * assumes: same clock as the slave; waits for pready with no fixed count.
 */
`timescale 1ns/1ps
module sndgen_host
(
  // clock
  input  wire         ref_clk_i,
  // apb master
  input  wire         pready_i,
  input  wire  [31:0] prdata_i,
  output logic        psel_o = 1'b0,
  output logic        penable_o = 1'b0,
  output logic        pwrite_o = 1'b0,
  output logic [31:0] paddr_o = 32'h0,
  output logic [31:0] pwdata_o = 32'h0,
  output logic [3:0]  pstrb_o = 4'h0
);
  // sound is set up only through register loads
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [7:0] q);
    @(posedge ref_clk_i);
    psel_o   <= 1'b1;
    pwrite_o <= w;
    paddr_o  <= a;
    pwdata_o <= ($urandom & 32'hffffff00) | {24'h0, d};
    pstrb_o  <= s;
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    do @(posedge ref_clk_i); while (pready_i !== 1'b1);
    q = prdata_i[7:0];
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // released address and data lines must not keep the last value
    paddr_o   <= ~a;
    pwdata_o  <= ~pwdata_o;
  endtask
endmodule

/* File: tb.sv */
/*
 * self-checking bench for the sound generator.
 * assumes: sndgen_host drives apb; the checker is bound to the top.
 */
`timescale 1ns/1ps
module tb;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  wire        psel, penable, pwrite, pready, pslverr;
  wire [31:0] paddr, pwdata, prdata;
  wire [3:0]  pstrb, lv_a, lv_b, lv_c;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         mdl[16];
  int         shp[6] = '{0, 4, 11, 12, 13, 14};
  int         n, m, k, s;
  logic [7:0] q;
  initial
  begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  sndgen_host sndgen_host_i (.ref_clk_i(ref_clk_i), .pready_i(pready), .prdata_i(prdata), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
  sndgen_top sndgen_top_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .level_a_o(lv_a), .level_b_o(lv_b), .level_c_o(lv_c));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input int i, input int d);
    sndgen_host_i.xfer(1'b1, 32'(i * 4), d[7:0], 4'hf, q);
    mdl[i] = d & 8'hff;
  endtask
  function logic [3:0] lv(input int c);
    return c == 0 ? lv_a : (c == 1 ? lv_b : lv_c);
  endfunction
  // envelope step expected k steps after a shape write
  function int env(input int sh, input int st);
    int c;
    int up;
    c = st / 16;
    if (!sh[3] && c > 0)
      return 0;
    if (sh[0] && c > 0)
      return (sh[2] ^ sh[1]) ? 15 : 0;
    up = sh[2] ^ (sh[1] & c[0]);
    return up ? st % 16 : 15 - st % 16;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(70));
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 16; i++)
      mdl[i] = (i == 7) ? 8'hff : 0;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 16; i++)
        if (i != 14)
        begin
          if (p == 1)
            wr(i, $urandom);
          sndgen_host_i.xfer(1'b0, 32'(i * 4), 8'h0, 4'hf, q);
          check("reg", q, mdl[i]);
        end
    sndgen_host_i.xfer(1'b1, 32'h0, 8'h5a, 4'h0, q);
    sndgen_host_i.xfer(1'b0, 32'h0, 8'h0, 4'hf, q);
    check("strobe", q, mdl[0]);
    sndgen_host_i.xfer(1'b0, 32'h40, 8'h0, 4'hf, q);
    check("high addr", q, 0);
    $display("test registers done");
    wr(7, 8'hff);
    for (int c = 0; c < 3; c++)
      wr(8 + c, $urandom & 8'hef);
    repeat (3) @(negedge ref_clk_i);
    for (int c = 0; c < 3; c++)
      check("fixed", lv(c), mdl[8 + c] & 15);
    $display("test fixed levels done");
    for (int c = 0; c < 3; c++)
    begin
      k = $urandom_range(5, 2);
      wr(8 + c, 8'h0f);
      wr(2 * c, k);
      wr(2 * c + 1, ($urandom & 8'hf0) | (c == 0));
      wr(7, 8'hff ^ (1 << c));
      repeat (2) @(negedge ref_clk_i);
      m = lv(c);
      while (lv(c) === m[3:0])
        @(negedge ref_clk_i);
      m = lv(c);
      n = 0;
      while (lv(c) === m[3:0])
      begin
        @(negedge ref_clk_i);
        n++;
      end
      check("tone half", n, 8 * (k + 256 * (c == 0)));
    end
    $display("test tone done");
    wr(6, 8'he1);
    wr(7, 8'hef);
    n = 0;
    for (int i = 0; i < 2000; i++)
    begin
      m = lv_b;
      @(negedge ref_clk_i);
      n += (lv_b !== m[3:0]);
    end
    check("noise", n > 10, 1);
    check("mix off", lv_a, 15);
    $display("test noise done");
    wr(7, 8'hff);
    wr(8, 8'h10);
    wr(11, 1);
    wr(12, 0);
    for (int j = 0; j < 6; j++)
    begin
      s = shp[j];
      wr(13, s);
      repeat (128) @(negedge ref_clk_i);
      for (k = 0; k < 40; k++)
      begin
        check("envelope", lv_a, env(s, k));
        sndgen_host_i.xfer(1'b0, 32'h38, 8'h0, 4'hf, q);
        check("step read", q, env(s, k));
        // the read above uses two and a half cycles of the step
        repeat (254) @(negedge ref_clk_i);
      end
    end
    $display("test envelope done");
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk_i);
    mismatches++;
    summarize();
  end
endmodule
